// >>> shared/gpb_defines.svh
// Offsets, field positions, reset values and pin masks of the port block.
// Assumes inclusion by bare name from the port module and its test bench.
`ifndef GPB_DEFINES_SVH
`define GPB_DEFINES_SVH
// ****************************************************************
// Register map
// ****************************************************************
`define GPB_ADDR_W 8
`define GPB_CFG_WORD 6'h00
`define GPB_MODE_MSB 31
`define GPB_MODE_LSB 24
`define GPB_DIR_MSB 23
`define GPB_DIR_LSB 16
`define GPB_DATA_MSB 7
`define GPB_DATA_LSB 0
`define GPB_GAP_ZERO 8'h00
`define GPB_STRB_MODE 3
`define GPB_STRB_DIR 2
`define GPB_STRB_DATA 0
`define GPB_MODE_RST 8'h00
`define GPB_DIR_RST 8'h00
`define GPB_DATA_RST 8'h00
`define GPB_RESP_OKAY 2'h0
`define GPB_RESP_SLVERR 2'h2
// ****************************************************************
// Pin roles
// ****************************************************************
`define GPB_PIN_TXD 7
`define GPB_PIN_DREQ 6
`define GPB_PIN_RTS 5
`define GPB_PIN_CLK 4
`define GPB_PIN_RXD 3
`define GPB_PIN_DSR 2
`define GPB_PIN_CTS 1
`define GPB_PIN_DCD 0
`define GPB_SF_HAS_OUT 8'hF7
`define GPB_SF_HAS_IN 8'h7F
`define GPB_RXD_IDLE 1'h1
`endif

// >>> shared/gpb_pkg.sv
// Types shared by the eight-pin port block.
// Assumes the defines header sits on the include path.
package gpb_pkg;
  // Pin configuration as {mode, direction}
  typedef enum logic [1:0] {
    CFG_GPIO_IN = 2'b00,
    CFG_GPIO_OUT = 2'b01,
    CFG_SF_IN = 2'b10,
    CFG_SF_OUT = 2'b11
  } gpb_pin_cfg_e;
  // Serial channel B towards the pads, internal polarity
  typedef struct packed {
    logic transmit_line;
    logic terminal_ready;
    logic request_send;
    logic spi_master;
    logic spi_slave;
    logic spi_master_clk;
    logic rx_clock_from_pin;
    logic rx_clock_export;
    logic receive_clock;
    logic gp_output_one;
  } gpb_ser_out_s;
  // Pads towards serial channel B, internal polarity
  typedef struct packed {
    logic receive_line;
    logic spi_slave_clk;
    logic receive_clock;
    logic set_ready;
    logic clear_send;
    logic carrier;
  } gpb_ser_in_s;
  // External DMA channel 4/6 state towards the pads
  typedef struct packed {
    logic req_enable;
    logic ext_cycle;
    logic done_out;
  } gpb_dma_out_s;
  // Pads towards the DMA engine, active high
  typedef struct packed {
    logic request;
    logic done_in;
  } gpb_dma_in_s;
endpackage

// >>> verilog/gpb_port.sv
// Eight-pin port with per-pin GPIO or special function selection.
// Assumes an AXI4-Lite master, pads with separate in/out/enable,
// and serial, DMA and MAC logic on the same clock.
//
// Notes on behaviour
// - Mode mask in bits 31:24, bit 31 is pin 7; 1 picks special function.
// - Direction mask in bits 23:16, bit 23 is pin 7; 1 picks output.
// - Data field reads each pin's present state in every configuration.
// - GPIO output pin drives the written data bit.
// - Data writes leave GPIO input and special function pins untouched.
// - GPIO output pin reads back the written data bit.
// - Mode 1 with direction 0 is function input, direction 1 output.
// - Pin 7 function output carries serial B transmit data.
// - Pin 6 function input is active-low DMA request when enabled.
// - Pin 6 function output is terminal ready, inverted at the pad.
// - Pin 5 function input is active-low MAC packet reject.
// - Pin 5 function output is request to send, inverted at the pad.
// - Pin 4 function input feeds SPI slave clock in slave mode.
// - Pin 4 function input feeds receive clock when taken from pin.
// - Pin 4 output is SPI master clock first when master.
// - Otherwise with export set, pin 4 outputs the receive clock.
// - Otherwise pin 4 outputs general output one, inverted.
// - Pin 3 function input carries serial B receive data.
// - Pin 2 out is DMA acknowledge low; in is set-ready.
// - Pin 1 out is frame start marker low; in is clear-to-send.
// - Pin 0 in is DMA done low when enabled; carrier then ignored.
`timescale 1ns/100ps
`include "gpb_defines.svh"

module gpb_port import gpb_pkg::*; (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [`GPB_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [`GPB_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [7:0] pad_in_i,
  output logic [7:0] pad_out_o,
  output logic [7:0] pad_oe_o,
  input wire gpb_ser_out_s ser_i,
  output gpb_ser_in_s ser_o,
  input wire gpb_dma_out_s dma_i,
  output gpb_dma_in_s dma_o,
  input wire logic rx_frame_start_i,
  output logic mac_reject_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic gpb_pin_cfg_e pin_cfg(input logic m, input logic d);
    return gpb_pin_cfg_e'({m, d});
  endfunction

  function automatic logic word_hit(input logic [`GPB_ADDR_W-1:0] a);
    return a[`GPB_ADDR_W-1:2] == `GPB_CFG_WORD;
  endfunction

  logic [7:0] pad_meta_q;
  logic [7:0] pad_sync_q;
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic [7:0] dir_q;
  logic [7:0] dir_d;
  logic [7:0] data_q;
  logic [7:0] data_d;
  logic [7:0] pad_out_q;
  logic [7:0] pad_out_d;
  logic [7:0] pad_oe_q;
  logic [7:0] pad_oe_d;
  logic [7:0] gout;
  logic [7:0] sfin;
  logic [7:0] sfout;
  logic [7:0] sf_val;
  logic [7:0] data_view;
  logic [7:0] data_wmask;
  gpb_ser_in_s ser_q;
  gpb_ser_in_s ser_d;
  gpb_dma_in_s dma_q;
  gpb_dma_in_s dma_d;
  logic reject_q;
  logic reject_d;

  // ****************************************************************
  // Pad input synchroniser
  // ****************************************************************
  // Pads are asynchronous; only the second stage feeds any logic
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      pad_meta_q <= 8'h00;
      pad_sync_q <= 8'h00;
    end else begin
      pad_meta_q <= pad_in_i;
      pad_sync_q <= pad_meta_q;
    end
  end

  // ****************************************************************
  // Pin configuration decode
  // ****************************************************************
  // One decoded role per pin
  for (genvar g = 0; g < 8; g++) begin : g_cfg
    assign gout[g] = pin_cfg(mode_q[g], dir_q[g]) == CFG_GPIO_OUT;
    assign sfin[g] = pin_cfg(mode_q[g], dir_q[g]) == CFG_SF_IN;
    assign sfout[g] = pin_cfg(mode_q[g], dir_q[g]) == CFG_SF_OUT;
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic aw_held_q;
  logic w_held_q;
  logic [`GPB_ADDR_W-1:0] awbuf_q;
  logic [31:0] wbuf_q;
  logic [3:0] sbuf_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_fire;
  logic wr_hit;
  logic rd_hit;

  // Address and data are parked until both have arrived
  assign s_axi_awready_o = !aw_held_q;
  assign s_axi_wready_o = !w_held_q;
  assign s_axi_arready_o = !rvalid_q;
  assign aw_hs = s_axi_awvalid_i && s_axi_awready_o;
  assign w_hs = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_hit = wr_fire && word_hit(awbuf_q);
  assign rd_hit = word_hit(s_axi_araddr_i);

  // Write channels; a new pair waits until the response is taken
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awbuf_q <= '0;
      wbuf_q <= 32'h00000000;
      sbuf_q <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_held_q <= 1'b1;
        awbuf_q <= s_axi_awaddr_i;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (w_hs) begin
        w_held_q <= 1'b1;
        wbuf_q <= s_axi_wdata_i;
        sbuf_q <= s_axi_wstrb_i;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped words answer SLVERR
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= `GPB_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? `GPB_RESP_OKAY : `GPB_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;

  // Data field shows what each pin really carries now
  for (genvar g = 0; g < 8; g++) begin : g_view
    assign data_view[g] = gout[g] ? data_q[g]
                        : pad_oe_q[g] ? pad_out_q[g] : pad_sync_q[g];
  end

  // Read answer; snapshot taken at the address edge
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      rvalid_q <= 1'b0;
      rresp_q <= `GPB_RESP_OKAY;
      rdata_q <= 32'h00000000;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_hit ? `GPB_RESP_OKAY : `GPB_RESP_SLVERR;
      rdata_q <= rd_hit ? {mode_q, dir_q, `GPB_GAP_ZERO, data_view} : 32'h00000000;
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rresp_o = rresp_q;
  assign s_axi_rdata_o = rdata_q;

  // ****************************************************************
  // Configuration register
  // ****************************************************************
  // Data bits land only on pins that are GPIO outputs before the write
  assign data_wmask = gout & {8{sbuf_q[`GPB_STRB_DATA]}};
  assign mode_d = (wr_hit && sbuf_q[`GPB_STRB_MODE])
                ? wbuf_q[`GPB_MODE_MSB:`GPB_MODE_LSB] : mode_q;
  assign dir_d = (wr_hit && sbuf_q[`GPB_STRB_DIR])
               ? wbuf_q[`GPB_DIR_MSB:`GPB_DIR_LSB] : dir_q;
  assign data_d = wr_hit
                ? (data_q & ~data_wmask)
                  | (wbuf_q[`GPB_DATA_MSB:`GPB_DATA_LSB] & data_wmask)
                : data_q;

  // Every pin starts as a GPIO input
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      mode_q <= `GPB_MODE_RST;
      dir_q <= `GPB_DIR_RST;
      data_q <= `GPB_DATA_RST;
    end else begin
      mode_q <= mode_d;
      dir_q <= dir_d;
      data_q <= data_d;
    end
  end

  // ****************************************************************
  // Special function outputs
  // ****************************************************************
  // Pad values, already in pad polarity
  assign sf_val[`GPB_PIN_TXD] = ser_i.transmit_line;
  assign sf_val[`GPB_PIN_DREQ] = !ser_i.terminal_ready;
  assign sf_val[`GPB_PIN_RTS] = !ser_i.request_send;
  assign sf_val[`GPB_PIN_CLK] = ser_i.spi_master ? ser_i.spi_master_clk
                              : ser_i.rx_clock_export ? ser_i.receive_clock
                              : !ser_i.gp_output_one;
  assign sf_val[`GPB_PIN_RXD] = 1'b0;
  assign sf_val[`GPB_PIN_DSR] = !(dma_i.req_enable && dma_i.ext_cycle);
  assign sf_val[`GPB_PIN_CTS] = !rx_frame_start_i;
  assign sf_val[`GPB_PIN_DCD] = !(dma_i.req_enable && dma_i.done_out);

  // Combinations with no function leave the pad undriven
  assign pad_out_d = (gout & data_q) | (sfout & sf_val);
  assign pad_oe_d = gout | (sfout & `GPB_SF_HAS_OUT);

  // Registered so pads never see decode glitches
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      pad_out_q <= 8'h00;
      pad_oe_q <= 8'h00;
    end else begin
      pad_out_q <= pad_out_d;
      pad_oe_q <= pad_oe_d;
    end
  end

  assign pad_out_o = pad_out_q;
  assign pad_oe_o = pad_oe_q;

  // ****************************************************************
  // Special function inputs
  // ****************************************************************
  // Clock inputs are sampled, so they must run well below core_clk_i
  assign ser_d.receive_line = sfin[`GPB_PIN_RXD]
                            ? pad_sync_q[`GPB_PIN_RXD] : `GPB_RXD_IDLE;
  assign ser_d.spi_slave_clk = sfin[`GPB_PIN_CLK] && ser_i.spi_slave
                             && pad_sync_q[`GPB_PIN_CLK];
  assign ser_d.receive_clock = sfin[`GPB_PIN_CLK] && ser_i.rx_clock_from_pin
                             && pad_sync_q[`GPB_PIN_CLK];
  assign ser_d.set_ready = sfin[`GPB_PIN_DSR] && !pad_sync_q[`GPB_PIN_DSR];
  assign ser_d.clear_send = sfin[`GPB_PIN_CTS] && !pad_sync_q[`GPB_PIN_CTS];
  // Carrier is masked while pin 0 serves as DMA done
  assign ser_d.carrier = sfin[`GPB_PIN_DCD] && !dma_i.req_enable
                       && !pad_sync_q[`GPB_PIN_DCD];
  assign dma_d.request = sfin[`GPB_PIN_DREQ] && dma_i.req_enable
                       && !pad_sync_q[`GPB_PIN_DREQ];
  assign dma_d.done_in = sfin[`GPB_PIN_DCD] && dma_i.req_enable
                       && !pad_sync_q[`GPB_PIN_DCD];
  assign reject_d = sfin[`GPB_PIN_RTS] && !pad_sync_q[`GPB_PIN_RTS];

  // Internal-side outputs from flops
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      ser_q <= '0;
      dma_q <= '0;
      reject_q <= 1'b0;
    end else begin
      ser_q <= ser_d;
      dma_q <= dma_d;
      reject_q <= reject_d;
    end
  end

  assign ser_o = ser_q;
  assign dma_o = dma_q;
  assign mac_reject_o = reject_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Steady configuration over a pad sample path
  sequence s_dreq_low;
    (sfin[`GPB_PIN_DREQ] && dma_i.req_enable && !pad_in_i[`GPB_PIN_DREQ])[*3];
  endsequence

  sequence s_reject_low;
    (sfin[`GPB_PIN_RTS] && !pad_in_i[`GPB_PIN_RTS])[*3];
  endsequence

  sequence s_dcd_low_dma;
    (sfin[`GPB_PIN_DCD] && dma_i.req_enable && !pad_in_i[`GPB_PIN_DCD])[*3];
  endsequence

  sequence s_rxd_pin;
    sfin[`GPB_PIN_RXD] [*3];
  endsequence

  chk_mode_write: assert property (
    wr_hit && sbuf_q[`GPB_STRB_MODE]
    |=> mode_q == $past(wbuf_q[`GPB_MODE_MSB:`GPB_MODE_LSB]))
    else $error("mode field not written");

  chk_dir_write: assert property (
    wr_hit && sbuf_q[`GPB_STRB_DIR] && !sbuf_q[`GPB_STRB_MODE]
    |=> dir_q == $past(wbuf_q[`GPB_DIR_MSB:`GPB_DIR_LSB]) && $stable(mode_q))
    else $error("direction field not written");

  chk_read_view: assert property (
    ar_hs && rd_hit
    |=> s_axi_rvalid_o && s_axi_rdata_o[`GPB_DATA_MSB:`GPB_DATA_LSB] == $past(data_view)
        && s_axi_rdata_o[`GPB_MODE_MSB:`GPB_MODE_LSB] == $past(mode_q))
    else $error("read data does not match pin state");

  chk_gpio_drive: assert property (
    ##1 ((pad_out_q & $past(gout)) == ($past(data_q) & $past(gout)))
        && ((pad_oe_q & $past(gout)) == $past(gout)))
    else $error("GPIO output pin not driving its data bit");

  chk_data_guard: assert property (
    wr_hit |=> (data_q & ~$past(gout)) == ($past(data_q) & ~$past(gout)))
    else $error("data write changed a non-output pin");

  chk_gpio_readback: assert property (
    ar_hs && rd_hit
    |=> (s_axi_rdata_o[`GPB_DATA_MSB:`GPB_DATA_LSB] & $past(gout))
        == ($past(data_q) & $past(gout)))
    else $error("GPIO output readback differs from data field");

  chk_sf_enable: assert property (
    ##1 (pad_oe_q & ~$past(dir_q)) == 8'h00 && (pad_oe_q & $past(mode_q & dir_q))
        == $past(mode_q & dir_q & `GPB_SF_HAS_OUT)) else $error("pad enable wrong");

  chk_txd_route: assert property (
    sfout[`GPB_PIN_TXD] |=> pad_out_q[`GPB_PIN_TXD] == $past(ser_i.transmit_line))
    else $error("transmit data not on pin 7");

  chk_dreq_path: assert property (
    s_dreq_low |=> dma_o.request)
    else $error("external DMA request not seen");

  chk_dtr_invert: assert property (
    sfout[`GPB_PIN_DREQ] |=> pad_out_q[`GPB_PIN_DREQ] != $past(ser_i.terminal_ready))
    else $error("terminal ready not inverted on pin 6");

  chk_reject_path: assert property (
    s_reject_low |=> mac_reject_o)
    else $error("reject input not passed to MAC");

  chk_rts_invert: assert property (
    sfout[`GPB_PIN_RTS] |=> pad_out_q[`GPB_PIN_RTS] != $past(ser_i.request_send))
    else $error("request to send not inverted on pin 5");

  chk_clk_out_pick: assert property (
    sfout[`GPB_PIN_CLK] && ser_i.spi_master
    |=> pad_out_q[`GPB_PIN_CLK] == $past(ser_i.spi_master_clk))
    else $error("SPI master clock lost priority on pin 4");

  chk_clk_out_rest: assert property (
    sfout[`GPB_PIN_CLK] && !ser_i.spi_master
    |=> pad_out_q[`GPB_PIN_CLK] == ($past(ser_i.rx_clock_export)
        ? $past(ser_i.receive_clock) : !$past(ser_i.gp_output_one)))
    else $error("pin 4 output selection wrong");

  chk_rxd_path: assert property (
    s_rxd_pin |=> ser_o.receive_line == $past(pad_in_i[`GPB_PIN_RXD], 3))
    else $error("receive data not taken from pin 3");

  chk_dack_drive: assert property (
    sfout[`GPB_PIN_DSR] && dma_i.req_enable && dma_i.ext_cycle
    |=> pad_oe_q[`GPB_PIN_DSR] && !pad_out_q[`GPB_PIN_DSR])
    else $error("DMA acknowledge not driven low");

  chk_frame_mark: assert property (
    sfout[`GPB_PIN_CTS] |=> pad_out_q[`GPB_PIN_CTS] == !$past(rx_frame_start_i))
    else $error("frame start marker wrong on pin 1");

  chk_done_path: assert property (
    s_dcd_low_dma |=> dma_o.done_in && !ser_o.carrier)
    else $error("DMA done lost or carrier not masked");

  chk_reset_state: assert property (@(posedge core_clk_i) disable iff (1'b0)
    !resetn_i |=> mode_q == `GPB_MODE_RST && dir_q == `GPB_DIR_RST && pad_oe_q == 8'h00)
    else $error("reset left a pin configured");

endmodule

// >>> dv/gpb_pad_model.sv
// Pad-side model: external devices sharing the eight port pads.
// Assumes per-pin enables from the port and levels set by the bench.
`timescale 1ns/100ps
module gpb_pad_model (
  input wire logic clk_i,
  input wire logic [7:0] pad_out_i,
  input wire logic [7:0] pad_oe_i,
  input wire logic [7:0] ext_lvl_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] pad_o
);
  logic [7:0] float_q;
  initial float_q = 8'h00;
  // Undriven pins toggle, so a stale level is never trusted
  always @(posedge clk_i) begin
    float_q <= ~float_q;
  end
  // Port driver first, then the external device, else floating
  // Reject and done inputs are driven low when asserted
  assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_lvl_i)
    | (~pad_oe_i & ~ext_en_i & float_q);
endmodule

// >>> dv/gpb_port_test.sv
// Self-checking bench for the eight-pin port with function select.
// Assumes the port package, its defines header and the pad model.
`timescale 1ns/100ps
`include "gpb_defines.svh"
module gpb_port_test import gpb_pkg::*; ;
  logic core_clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'h0;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0, rx_frame_start_i = 1'h0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, mac_reject_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [7:0] pad_in_i, pad_out_o, pad_oe_o;
  logic [7:0] ext_lvl = 8'h00, ext_en = 8'hFF;
  gpb_ser_out_s ser_i = '0;
  gpb_ser_in_s ser_o;
  gpb_dma_out_s dma_i = '0;
  gpb_dma_in_s dma_o;
  int err_count = 0;
  int cmp_count = 0;

  always #5 core_clk_i = ~core_clk_i;

  gpb_port DUT (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
    .pad_oe_o(pad_oe_o), .ser_i(ser_i), .ser_o(ser_o), .dma_i(dma_i), .dma_o(dma_o),
    .rx_frame_start_i(rx_frame_start_i), .mac_reject_o(mac_reject_o));
  gpb_pad_model pads (.clk_i(core_clk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
    .ext_lvl_i(ext_lvl), .ext_en_i(ext_en), .pad_o(pad_in_i));

  // ****************************************************************
  // Bus cycles and comparisons
  // ****************************************************************
  // Ready is looked at mid-cycle; inputs only move just after an edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
    logic ka, kw, tb;
    tb = 1'h0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= s;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    while (!tb) begin
      @(negedge core_clk_i);
      ka = s_axi_awready_o && s_axi_awvalid_i;
      kw = s_axi_wready_o && s_axi_wvalid_i;
      tb = s_axi_bvalid_o;
      r = s_axi_bresp_o;
      @(posedge core_clk_i);
      if (ka) s_axi_awvalid_i <= 1'h0;
      if (kw) s_axi_wvalid_i <= 1'h0;
    end
    s_axi_bready_i <= 1'h0;
    @(posedge core_clk_i);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ka, tr;
    tr = 1'h0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    while (!tr) begin
      @(negedge core_clk_i);
      ka = s_axi_arready_o && s_axi_arvalid_i;
      tr = s_axi_rvalid_o;
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge core_clk_i);
      if (ka) s_axi_arvalid_i <= 1'h0;
    end
    s_axi_rready_i <= 1'h0;
    @(posedge core_clk_i);
  endtask

  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    axw(8'h00, d, s, r);
    chk8("bresp", {6'h00, `GPB_RESP_OKAY}, {6'h00, r});
  endtask

  task automatic rdchk(input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(8'h00, d, r);
    chk32("register", e, d);
  endtask

  // Pad inputs need two sync flops and an output flop
  task automatic settle;
    repeat (4) @(posedge core_clk_i);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rdchk(32'h00000000);
    chk8("pad_oe", 8'h00, pad_oe_o);
  endtask

  task automatic t_gpio_out;
    wr(32'h00FF0000, 4'hC);
    wr(32'h000000A5, 4'h1);
    settle();
    chk8("pad_oe", 8'hFF, pad_oe_o);
    chk8("pad_out", 8'hA5, pad_out_o);
    rdchk(32'h00FF00A5);
  endtask

  task automatic t_gpio_in;
    ext_en <= 8'hFF;
    ext_lvl <= 8'h3C;
    wr(32'h00000000, 4'hC);
    wr(32'h0000005A, 4'h1);
    settle();
    rdchk(32'h0000003C);
    wr(32'h00FF0000, 4'hC);
    settle();
    chk8("pad_out", 8'hA5, pad_out_o);
  endtask

  task automatic t_sf_out;
    // Per row: master, master clock, export, receive clock, output one, pin
    logic [5:0] tbl [5] = '{6'h3B, 6'h2C, 6'h1F, 6'h16, 6'h01};
    ser_i.transmit_line <= 1'h1;
    ser_i.terminal_ready <= 1'h1;
    ser_i.gp_output_one <= 1'h1;
    dma_i <= 3'h6;
    rx_frame_start_i <= 1'h1;
    ext_lvl <= 8'h08;
    wr(32'hFFF70000, 4'hC);
    settle();
    chk8("pad_oe", 8'hF7, pad_oe_o);
    chk8("pad_out", 8'hA1, pad_out_o & 8'hF7);
    rdchk(32'hFFF700A9);
    foreach (tbl[i]) begin
      ser_i.spi_master <= tbl[i][5];
      ser_i.spi_master_clk <= tbl[i][4];
      ser_i.rx_clock_export <= tbl[i][3];
      ser_i.receive_clock <= tbl[i][2];
      ser_i.gp_output_one <= tbl[i][1];
      settle();
      chk8("pin4", {7'h00, tbl[i][0]}, {7'h00, pad_out_o[4]});
    end
    // Flip the pin 7, 6, 5, 2, 1 and 0 sources so a pin stuck at one level shows up
    ser_i.transmit_line <= 1'h0;
    ser_i.terminal_ready <= 1'h0;
    ser_i.request_send <= 1'h1;
    dma_i <= 3'h5;
    rx_frame_start_i <= 1'h0;
    settle();
    chk8("pad_inv", 8'h56, pad_out_o & 8'hF7);
  endtask

  task automatic t_sf_in;
    // Per phase: pad level, request enable, serial inputs, dma and reject
    logic [31:0] t [3] = '{32'h00010607, 32'h7F013800, 32'h00000701};
    ser_i.spi_slave <= 1'h1;
    ser_i.rx_clock_from_pin <= 1'h1;
    ser_i.transmit_line <= 1'h1;
    wr(32'hFF800000, 4'hC);
    for (int i = 0; i < 3; i++) begin
      ext_lvl <= t[i][31:24];
      dma_i.req_enable <= t[i][16];
      settle();
      chk8("ser", t[i][15:8], {2'h0, ser_o});
      chk8("dma_rej", t[i][7:0], {5'h00, dma_o, mac_reject_o});
    end
    chk8("pad_oe", 8'h80, pad_oe_o);
  endtask

  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0] r;
    axw(8'h04, 32'hFFFFFFFF, 4'hF, r);
    chk8("bresp", {6'h00, `GPB_RESP_SLVERR}, {6'h00, r});
    axr(8'h04, d, r);
    chk8("rresp", {6'h00, `GPB_RESP_SLVERR}, {6'h00, r});
    chk32("rdata", 32'h00000000, d);
    rdchk(32'hFF800080);
  endtask

  // ****************************************************************
  // Sequence, watchdog and verdict
  // ****************************************************************
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge core_clk_i);
    resetn_i <= 1'h1;
    @(posedge core_clk_i);
    t_reset();
    t_gpio_out();
    t_gpio_in();
    t_sf_out();
    t_sf_in();
    t_unmapped();
    results();
  end

  // Tests need about a hundred and ten cycles; twenty thousand means a hang
  initial begin
    #200000;
    err_count++;
    results();
  end
endmodule
